//--- slbx_core.sv
// stack and operate-and-branch execution unit
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - compare-and-branch jumps only when its operands differ, else falls through.
// - carry set when first operand below second unsigned, cleared otherwise.
// - compare leaves operands untouched; only carry and program counter change.
// - decrement operand, write back, branch if nonzero, flags unchanged.
// - decrement-and-branch always takes two machine cycles.
// - both branches add signed displacement to incremented program counter.
// - push increments stack pointer then writes direct byte there.
// - push source is direct-addressed byte only.
// - pop reads byte at stack pointer, stores it, then decrements.
// - stack uses internal RAM addressing like register-indirect access.
// - call and interrupt entry push return address low then high.
// - interrupt entry stacks only the return address; prior acceptance level kept internally.
// - interrupt return pops address and restores interrupt acceptance state.
module slbx_core (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // instruction issue
    input wire logic i_start,
    input wire logic [2:0] i_op,
    input wire logic [7:0] i_opnd_a,
    input wire logic [7:0] i_opnd_b,
    input wire logic [7:0] i_rel,
    input wire logic [15:0] i_next_pc,
    input wire logic [15:0] i_target,
    input wire logic [1:0] i_intr_level,
    // internal ram read data
    input wire logic [7:0] i_ram_rdata,
    // status
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_pc,
    output logic o_carry,
    output logic o_carry_we,
    output logic [7:0] o_stack_pointer,
    output logic [1:0] o_intr_active,
    // operand write-back
    output logic o_dst_we,
    output logic [7:0] o_dst_data,
    // internal ram port
    output logic o_ram_we,
    output logic o_ram_re,
    output logic [7:0] o_ram_addr,
    output logic [7:0] o_ram_wdata
);
    // ********************************
    // helpers
    // ********************************
    function automatic logic [15:0] rel_dest(input logic [15:0] pc,
                                             input logic [7:0] rel);
        rel_dest = pc + {{8{rel[7]}}, rel};
    endfunction : rel_dest

    slbx_pkg::slbx_state_type state_reg, state_next;
    logic [2:0] op_reg;
    logic [7:0] sp_reg;
    logic [15:0] pc_reg;
    logic [15:0] ret_reg;
    logic [15:0] tgt_reg;
    logic [7:0] a_reg;
    logic [7:0] b_reg;
    logic [7:0] rel_reg;
    logic [7:0] lo_reg;
    logic [1:0] prio_reg;
    logic [1:0] prio_save_reg;
    logic [1:0] mc_reg;
    logic carry_reg;
    logic carry_we_reg;
    logic done_reg;
    logic dst_we_reg;
    logic [7:0] dst_reg;

    // ********************************
    // datapath decode
    // ********************************
    wire logic [7:0] sp_inc = sp_reg + 8'h01; // wraps
    wire logic [7:0] sp_dec = sp_reg - 8'h01; // wraps
    wire logic operands_differ = (a_reg != b_reg);
    wire logic first_below = (a_reg < b_reg);
    wire logic [7:0] dec_val = a_reg - 8'h01;
    wire logic dec_nonzero = (dec_val != 8'h00);
    wire logic [15:0] branch_dest = rel_dest(ret_reg, rel_reg);
    wire logic in_exec = (state_reg == slbx_pkg::SLBX_EXEC);
    wire logic exec_last = in_exec &&
        ((op_reg != slbx_pkg::OP_DEC_BRANCH) ||
         (mc_reg == slbx_pkg::MC_TWO - 2'h1));
    // stack uses plain ram addressing, never the register space
    wire logic push_wr = in_exec && (op_reg == slbx_pkg::OP_PUSH);
    wire logic pop_rd = in_exec && (op_reg == slbx_pkg::OP_POP);
    wire logic wr_lo = (state_reg == slbx_pkg::SLBX_WR_LO);
    wire logic wr_hi = (state_reg == slbx_pkg::SLBX_WR_HI);
    wire logic rd_hi = (state_reg == slbx_pkg::SLBX_RD_HI);
    wire logic rd_lo = (state_reg == slbx_pkg::SLBX_RD_LO);

    assign o_ram_we = push_wr || wr_lo || wr_hi;
    assign o_ram_re = pop_rd || rd_hi || rd_lo;
    // push writes at the already-advanced pointer
    assign o_ram_addr = sp_reg;
    // push takes the fetched direct byte only
    assign o_ram_wdata = push_wr ? a_reg :
                         wr_lo ? ret_reg[7:0] : ret_reg[15:8];
    assign o_busy = (state_reg != slbx_pkg::SLBX_IDLE);
    assign o_done = done_reg;
    assign o_pc = pc_reg;
    assign o_carry = carry_reg;
    assign o_carry_we = carry_we_reg;
    assign o_stack_pointer = sp_reg;
    assign o_intr_active = prio_reg;
    assign o_dst_we = dst_we_reg;
    assign o_dst_data = dst_reg;

    // ********************************
    // sequencing
    // ********************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slbx_pkg::SLBX_IDLE: begin
                if (i_start && i_op != slbx_pkg::OP_NONE) begin
                    state_next = slbx_pkg::SLBX_EXEC;
                end
            end
            slbx_pkg::SLBX_EXEC: begin
                if (op_reg == slbx_pkg::OP_CALL ||
                    op_reg == slbx_pkg::OP_INTR_ENTRY) begin
                    state_next = slbx_pkg::SLBX_WR_LO;
                end else if (op_reg == slbx_pkg::OP_INTR_RETURN) begin
                    state_next = slbx_pkg::SLBX_RD_HI;
                end else if (exec_last) begin
                    state_next = slbx_pkg::SLBX_IDLE;
                end
            end
            slbx_pkg::SLBX_WR_LO: state_next = slbx_pkg::SLBX_WR_HI;
            slbx_pkg::SLBX_RD_HI: state_next = slbx_pkg::SLBX_RD_LO;
            default: state_next = slbx_pkg::SLBX_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= slbx_pkg::SLBX_IDLE;
            op_reg <= slbx_pkg::OP_NONE;
            sp_reg <= slbx_pkg::SP_RESET;
            pc_reg <= slbx_pkg::PC_RESET;
            ret_reg <= slbx_pkg::PC_RESET;
            tgt_reg <= slbx_pkg::PC_RESET;
            a_reg <= 8'h00;
            b_reg <= 8'h00;
            rel_reg <= 8'h00;
            lo_reg <= 8'h00;
            prio_reg <= slbx_pkg::PRIO_RESET;
            prio_save_reg <= slbx_pkg::PRIO_RESET;
            mc_reg <= 2'h0;
            carry_reg <= 1'b0;
            carry_we_reg <= 1'b0;
            done_reg <= 1'b0;
            dst_we_reg <= 1'b0;
            dst_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            done_reg <= 1'b0;
            carry_we_reg <= 1'b0;
            dst_we_reg <= 1'b0;
            if (state_reg == slbx_pkg::SLBX_IDLE && i_start &&
                i_op != slbx_pkg::OP_NONE) begin
                op_reg <= i_op;
                a_reg <= i_opnd_a;
                b_reg <= i_opnd_b;
                rel_reg <= i_rel;
                ret_reg <= i_next_pc;
                tgt_reg <= i_target;
                mc_reg <= 2'h0;
                if (i_op == slbx_pkg::OP_PUSH) begin
                    sp_reg <= sp_inc;
                end
            end
            if (in_exec) begin
                mc_reg <= mc_reg + 2'h1;
                case (op_reg)
                    slbx_pkg::OP_CMP_BRANCH: begin
                        // operands are never written back
                        carry_reg <= first_below;
                        carry_we_reg <= 1'b1;
                        pc_reg <= operands_differ ? branch_dest
                                                  : ret_reg;
                    end
                    slbx_pkg::OP_DEC_BRANCH: begin
                        if (exec_last) begin
                            // no flag write here
                            dst_reg <= dec_val;
                            dst_we_reg <= 1'b1;
                            pc_reg <= dec_nonzero ? branch_dest : ret_reg;
                        end
                    end
                    slbx_pkg::OP_PUSH: begin
                        pc_reg <= ret_reg;
                    end
                    slbx_pkg::OP_POP: begin
                        dst_reg <= i_ram_rdata;
                        dst_we_reg <= 1'b1;
                        sp_reg <= sp_dec; // after the read
                        pc_reg <= ret_reg;
                    end
                    slbx_pkg::OP_CALL, slbx_pkg::OP_INTR_ENTRY: begin
                        sp_reg <= sp_inc;
                        if (op_reg == slbx_pkg::OP_INTR_ENTRY) begin
                            // only acceptance level kept; no status saved
                            prio_save_reg <= prio_reg;
                            prio_reg <= i_intr_level;
                        end
                    end
                    default: begin
                    end
                endcase
                if (exec_last && op_reg != slbx_pkg::OP_CALL &&
                    op_reg != slbx_pkg::OP_INTR_ENTRY &&
                    op_reg != slbx_pkg::OP_INTR_RETURN) begin
                    done_reg <= 1'b1;
                end
            end
            if (wr_lo) begin
                sp_reg <= sp_inc;
            end
            if (wr_hi) begin
                pc_reg <= tgt_reg;
                done_reg <= 1'b1;
            end
            if (rd_hi) begin
                lo_reg <= i_ram_rdata;
                sp_reg <= sp_dec;
            end
            if (rd_lo) begin
                pc_reg <= {lo_reg, i_ram_rdata};
                sp_reg <= sp_dec;
                prio_reg <= prio_save_reg;
                done_reg <= 1'b1;
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking chk_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    chk_cmp_carry: assert property (in_exec &&
        op_reg == slbx_pkg::OP_CMP_BRANCH |=> o_carry_we &&
        o_carry == ($past(a_reg) < $past(b_reg)))
        else $error("compare carry wrong");
    chk_cmp_branch: assert property (in_exec &&
        op_reg == slbx_pkg::OP_CMP_BRANCH && !operands_differ |=>
        o_pc == $past(ret_reg))
        else $error("equal compare branched");
    chk_cmp_nowrite: assert property (in_exec &&
        op_reg == slbx_pkg::OP_CMP_BRANCH |=> !o_dst_we)
        else $error("compare wrote an operand");
    chk_dec_flags: assert property (in_exec &&
        op_reg == slbx_pkg::OP_DEC_BRANCH |=> !o_carry_we && $stable(o_carry))
        else $error("decrement touched carry");
    chk_dec_two: assert property (i_start && !o_busy &&
        i_op == slbx_pkg::OP_DEC_BRANCH |=> !o_done [*2] ##1 o_done)
        else $error("decrement not two cycles");
    chk_dec_rel: assert property (exec_last && dec_nonzero &&
        op_reg == slbx_pkg::OP_DEC_BRANCH |=> o_pc ==
        $past(ret_reg) + {{8{$past(rel_reg[7])}}, $past(rel_reg)})
        else $error("relative target wrong");
    chk_push_order: assert property (i_start && !o_busy &&
        i_op == slbx_pkg::OP_PUSH |=> o_ram_we &&
        o_ram_addr == $past(sp_reg) + 8'h01 &&
        o_ram_wdata == $past(i_opnd_a))
        else $error("push order wrong");
    chk_pop_order: assert property (pop_rd |-> o_ram_re &&
        o_ram_addr == o_stack_pointer ##1 o_dst_we &&
        o_stack_pointer == $past(o_stack_pointer) - 8'h01 &&
        o_dst_data == $past(i_ram_rdata)) else $error("pop order wrong");
    chk_call_bytes: assert property (wr_lo |-> o_ram_we &&
        o_ram_wdata == ret_reg[7:0] ##1 wr_hi && o_ram_we &&
        o_ram_wdata == ret_reg[15:8] &&
        o_ram_addr == $past(o_ram_addr) + 8'h01)
        else $error("return address order wrong");
    chk_interrupt_return_prio: assert property (rd_lo |=>
        o_intr_active == $past(prio_save_reg))
        else $error("interrupt state not restored");
    cov_cmp_taken: cover property (in_exec &&
        op_reg == slbx_pkg::OP_CMP_BRANCH && operands_differ);
    cov_dec_loop: cover property (exec_last &&
        op_reg == slbx_pkg::OP_DEC_BRANCH && dec_nonzero);
    cov_intr_entry: cover property (wr_hi);
    cov_interrupt_return: cover property (rd_lo);
endmodule : slbx_core
`default_nettype wire

//--- slbx_pkg.sv
// shared constants for the stack and loop-branch execution block
package slbx_pkg;
    // ********************************
    // operation codes
    // ********************************
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_CMP_BRANCH = 3'h1;
    localparam logic [2:0] OP_DEC_BRANCH = 3'h2;
    localparam logic [2:0] OP_PUSH = 3'h3;
    localparam logic [2:0] OP_POP = 3'h4;
    localparam logic [2:0] OP_CALL = 3'h5;
    localparam logic [2:0] OP_INTR_ENTRY = 3'h6;
    localparam logic [2:0] OP_INTR_RETURN = 3'h7;
    // ********************************
    // reset values and cycle counts
    // ********************************
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [1:0] MC_TWO = 2'h2;
    // ********************************
    // execution states
    // ********************************
    typedef enum logic [2:0] {
        SLBX_IDLE = 3'h0,
        SLBX_EXEC = 3'h1,
        SLBX_WR_LO = 3'h3,
        SLBX_WR_HI = 3'h2,
        SLBX_RD_HI = 3'h6,
        SLBX_RD_LO = 3'h7
    } slbx_state_type;
endpackage : slbx_pkg

//--- stack_and_loop_branch_exec_tb.sv
// self-checking testbench for the stack and loop-branch execution unit
`timescale 1ns/10ps
`default_nettype none
module stack_and_loop_branch_exec_tb;
    // ********************************
    // stimulus, ram model, bookkeeping
    // ********************************
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_start = 1'b0;
    logic [2:0] i_op = 3'h0;
    logic [7:0] i_opnd_a = 8'h00;
    logic [7:0] i_opnd_b = 8'h00;
    logic [7:0] i_rel = 8'h00;
    logic [15:0] i_next_pc = 16'h0000;
    logic [15:0] i_target = 16'h0000;
    logic [1:0] i_intr_level = 2'h0;
    wire logic [7:0] i_ram_rdata;
    logic o_busy, o_done, o_carry, o_carry_we, o_dst_we, o_ram_we, o_ram_re;
    logic [15:0] o_pc;
    logic [7:0] o_stack_pointer, o_dst_data, o_ram_addr, o_ram_wdata;
    logic [1:0] o_intr_active;
    logic [7:0] ram [0:255];
    logic [7:0] sp_exp = 8'h07;
    logic carry_exp = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int wr_n = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    // unselected ram shows a changing pattern, never the last value
    assign i_ram_rdata = (o_ram_re === 1'b1) ? ram[o_ram_addr] : ~cyc[7:0];
    always @(posedge i_clk_sys) begin
        cyc++;
        if (o_ram_we === 1'b1) begin
            ram[o_ram_addr] <= o_ram_wdata;
            wr_n++;
        end
        if (cyc > 4000) begin
            err_count++;
            close_out();
        end
    end
    slbx_core dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_start(i_start), .i_op(i_op), .i_opnd_a(i_opnd_a),
        .i_opnd_b(i_opnd_b), .i_rel(i_rel), .i_next_pc(i_next_pc),
        .i_target(i_target), .i_intr_level(i_intr_level),
        .i_ram_rdata(i_ram_rdata), .o_busy(o_busy), .o_done(o_done),
        .o_pc(o_pc), .o_carry(o_carry), .o_carry_we(o_carry_we),
        .o_stack_pointer(o_stack_pointer), .o_intr_active(o_intr_active),
        .o_dst_we(o_dst_we), .o_dst_data(o_dst_data), .o_ram_we(o_ram_we),
        .o_ram_re(o_ram_re), .o_ram_addr(o_ram_addr),
        .o_ram_wdata(o_ram_wdata));
    // ********************************
    // shared tasks
    // ********************************
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask : chk
    task close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // issue one op and count cycles from the issue cycle to the done pulse
    task automatic issue(input logic [2:0] op, input logic [7:0] a, b, r,
            input logic [15:0] np, tg, input logic [1:0] lv, input int nc);
        int n;
        @(posedge i_clk_sys);
        i_start <= 1'b1;
        i_op <= op;
        i_opnd_a <= a;
        i_opnd_b <= b;
        i_rel <= r;
        i_next_pc <= np;
        i_target <= tg;
        i_intr_level <= lv;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        wr_n = 0;
        // the issue cycle itself counts as the first
        n = 1;
        #1;
        chk("busy", 16'h0001, 16'(o_busy));
        while (o_done !== 1'b1 && n < 12) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk("cycles", 16'(nc), 16'(n));
    endtask : issue
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        chk("pc", slbx_pkg::PC_RESET, o_pc);
        chk("sp", 16'(slbx_pkg::SP_RESET), 16'(o_stack_pointer));
        chk("carry", 16'h0000, 16'(o_carry));
        chk("busy", 16'h0000, 16'(o_busy));
        chk("intr_active", 16'h0000, 16'(o_intr_active));
    endtask : t_reset
    task automatic t_cmp();
        logic [7:0] av [4] = '{8'h10, 8'h30, 8'h55, 8'h00};
        logic [7:0] bv [4] = '{8'h20, 8'h20, 8'h55, 8'hFF};
        logic [7:0] rv [4] = '{8'hF0, 8'h05, 8'h7F, 8'h80};
        logic [15:0] pe;
        for (int k = 0; k < 4; k++) begin
            issue(slbx_pkg::OP_CMP_BRANCH, av[k], bv[k], rv[k], 16'h0100,
                16'h0000, 2'h0, 2);
            pe = 16'h0100 + {{8{rv[k][7]}}, rv[k]};
            chk("cmp pc", (av[k] != bv[k]) ? pe : 16'h0100, o_pc);
            carry_exp = (av[k] < bv[k]);
            chk("cmp carry", 16'(carry_exp), 16'(o_carry));
            chk("cmp carry_we", 16'h0001, 16'(o_carry_we));
            chk("cmp dst_we", 16'h0000, 16'(o_dst_we));
        end
    endtask : t_cmp
    task automatic t_dec(input logic [7:0] a, r);
        logic [7:0] d;
        d = a - 8'h01;
        issue(slbx_pkg::OP_DEC_BRANCH, a, 8'h00, r, 16'h0200, 16'h0000,
            2'h0, 3);
        chk("dec data", 16'(d), 16'(o_dst_data));
        chk("dec dst_we", 16'h0001, 16'(o_dst_we));
        chk("dec pc", (d != 8'h00) ? 16'h0200 + {{8{r[7]}}, r} : 16'h0200,
            o_pc);
        chk("dec carry", 16'(carry_exp), 16'(o_carry));
    endtask : t_dec
    task automatic t_push(input logic [7:0] a);
        sp_exp = sp_exp + 8'h01;
        issue(slbx_pkg::OP_PUSH, a, 8'h00, 8'h00, 16'h0300, 16'h0000,
            2'h0, 2);
        chk("push sp", 16'(sp_exp), 16'(o_stack_pointer));
        chk("push ram", 16'(a), 16'(ram[sp_exp]));
        chk("push writes", 16'h0001, 16'(wr_n));
    endtask : t_push
    task automatic t_pop();
        logic [7:0] e;
        e = ram[sp_exp];
        issue(slbx_pkg::OP_POP, 8'h00, 8'h00, 8'h00, 16'h0300, 16'h0000,
            2'h0, 2);
        sp_exp = sp_exp - 8'h01;
        chk("pop data", 16'(e), 16'(o_dst_data));
        chk("pop dst_we", 16'h0001, 16'(o_dst_we));
        chk("pop sp", 16'(sp_exp), 16'(o_stack_pointer));
    endtask : t_pop
    task automatic t_call(input logic [2:0] op, input logic [1:0] lv);
        logic [7:0] s1, s2;
        s1 = sp_exp + 8'h01;
        s2 = sp_exp + 8'h02;
        issue(op, 8'h00, 8'h00, 8'h00, 16'h0ABC, 16'h1234, lv, 4);
        sp_exp = s2;
        chk("call low", 16'h00BC, 16'(ram[s1]));
        chk("call high", 16'h000A, 16'(ram[s2]));
        chk("call sp", 16'(sp_exp), 16'(o_stack_pointer));
        chk("call writes", 16'h0002, 16'(wr_n));
        chk("call pc", 16'h1234, o_pc);
        chk("active", 16'(lv), 16'(o_intr_active));
    endtask : t_call
    task automatic t_return();
        issue(slbx_pkg::OP_INTR_RETURN, 8'h00, 8'h00, 8'h00, 16'h0000,
            16'h0000, 2'h0, 4);
        sp_exp = sp_exp - 8'h02;
        chk("ret pc", 16'h0ABC, o_pc);
        chk("ret sp", 16'(sp_exp), 16'(o_stack_pointer));
        chk("ret active", 16'h0000, 16'(o_intr_active));
    endtask : t_return
    // ********************************
    // main sequence
    // ********************************
    initial begin
        for (int k = 0; k < 256; k++)
            ram[k] = 8'(k) ^ 8'h3C;
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        #1;
        t_reset();
        t_cmp();
        t_dec(8'h01, 8'hFE);
        t_dec(8'h00, 8'hFE);
        t_dec(8'h80, 8'h10);
        t_push(8'hAA);
        t_push(8'h5B);
        t_pop();
        t_pop();
        // walk the pointer down through zero to check the wrap
        repeat (8) t_pop();
        t_push(8'hC3);
        t_call(slbx_pkg::OP_CALL, 2'h0);
        t_call(slbx_pkg::OP_INTR_ENTRY, 2'h2);
        t_return();
        close_out();
    end
endmodule : stack_and_loop_branch_exec_tb
`default_nettype wire
